// ---- core/eiu_pkg.sv ----
// package for the external interrupt front end: register map, layouts, reset values
package eiu_pkg;
    // register byte offsets
    localparam logic [7:0] EIU_OFS_IER    = 8'h00;
    localparam logic [7:0] EIU_OFS_IDR    = 8'h04;
    localparam logic [7:0] EIU_OFS_IMR    = 8'h08;
    localparam logic [7:0] EIU_OFS_ISR    = 8'h0c;
    localparam logic [7:0] EIU_OFS_ICR    = 8'h10;
    localparam logic [7:0] EIU_OFS_MODE   = 8'h14;
    localparam logic [7:0] EIU_OFS_EDGE   = 8'h18;
    localparam logic [7:0] EIU_OFS_LEVEL  = 8'h1c;
    localparam logic [7:0] EIU_OFS_FILTER = 8'h20;
    localparam logic [7:0] EIU_OFS_ASYNCHRONOUS_SELECT  = 8'h28;
    localparam logic [7:0] EIU_OFS_SCAN   = 8'h2c;
    localparam logic [7:0] EIU_OFS_EN     = 8'h30;
    localparam logic [7:0] EIU_OFS_DIS    = 8'h34;
    localparam logic [7:0] EIU_OFS_CTRL   = 8'h38;
    // scan register field positions
    localparam int EIU_SCAN_EN_BIT = 0;
    localparam int EIU_SCAN_PRESC_LSB = 8;
    localparam int EIU_SCAN_PRESC_W = 5;
    localparam int EIU_SCAN_PIN_LSB = 24;
    localparam int EIU_SCAN_PIN_W = 3;
    // reset values
    localparam logic [31:0] EIU_RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] EIU_RST_UNMAPPED = 32'h0000_0000;
    // sampling depth of the pin synchroniser and of the filter window
    localparam int EIU_SYNC_STAGES = 2;
    localparam int EIU_FILT_DEPTH = 3;

    typedef struct packed {
        logic [7:0]  adr;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] dat;
    } eiu_wb_req_t;

    typedef enum logic [0:0] {
        EIU_SCAN_IDLE = 1'b0,
        EIU_SCAN_RUN  = 1'b1
    } eiu_scan_state_t;
endpackage

// ---- core/eiu_external_irq_unit.sv ----
// external interrupt front end with keypad scan and wishbone registers
//
// What this block does
// - one maskable request output per input
// - rising, falling, high or low triggering
// - per-input switchable spike filter
// - per-input asynchronous detection for clockless wake
// - nmi input same features, to cpu
// - wake request without interrupt when masked
// - scan outputs drive columns, rows on inputs
// - key press interrupts, column index readable
// - mode bit edge/level, polarity bit selects
// - two flop synchroniser before detection
// - filter is majority of three samples
// - asynchronous_select acts as level, no filter
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module eiu_external_irq_unit #(
    parameter int NUM_IRQ = 8,
    parameter int NUM_SCAN = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_IRQ-1:0] ext_irq_pin_i,
    input wire logic nmi_pin_i,
    output logic [NUM_IRQ-1:0] irq_o,
    output logic nmi_req_o,
    output logic wake_request_o,
    output logic [NUM_SCAN-1:0] keypad_column_out_o,
    output logic [NUM_SCAN-1:0] keypad_column_oe_n_o
);
    localparam int N = NUM_IRQ + 1;
    localparam int NMI_BIT = NUM_IRQ;
    localparam int SW = $clog2(NUM_SCAN);

    ////////////////////////////////////////////////////////////////////////
    eiu_pkg::eiu_wb_req_t req;
    logic [N-1:0] pin_all;
    logic [N-1:0] ctrl_ff, imr_ff, isr_ff, mode_ff, edge_ff, level_ff;
    logic [N-1:0] filt_ff, asynchronous_select_ff;
    logic [N-1:0] sync1_ff, sync2_ff, hist1_ff, hist2_ff, prev_ff;
    logic [N-1:0] trig, asynchronous_select_hit, nxt_isr;
    logic [N-1:0] wr_ier, wr_idr, wr_icr, wr_en, wr_dis;
    logic [31:0] wr_data;
    logic [31:0] nxt_rdata;
    logic wr_stb, rd_stb;
    logic scan_en_ff;
    logic [eiu_pkg::EIU_SCAN_PRESC_W-1:0] scan_presc_ff;
    logic [SW-1:0] scan_col_ff, scan_pin_ff;
    logic [31:0] scan_cnt_ff;
    eiu_pkg::eiu_scan_state_t scan_state_ff;
    logic [31:0] wb_dat_ff;
    logic wb_ack_ff;
    logic [NUM_IRQ-1:0] irq_ff;
    logic nmi_ff, wake_ff;
    logic [NUM_SCAN-1:0] col_ff, col_oe_n_ff;

    assign pin_all = {nmi_pin_i, ext_irq_pin_i};
    assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
    // one ack per access; a wait state keeps the ack single-cycle
    assign wr_stb = wb_cyc_i && wb_stb_i && req.we && !wb_ack_ff;
    assign rd_stb = wb_cyc_i && wb_stb_i && !req.we && !wb_ack_ff;
    // unselected byte lanes write as zero, they do not keep old bits
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_data[8*b +: 8] = req.sel[b] ? req.dat[8*b +: 8] : 8'h00;
        end
    end
    assign wr_ier = (wr_stb && req.adr == eiu_pkg::EIU_OFS_IER) ? wr_data[N-1:0] : '0;
    assign wr_idr = (wr_stb && req.adr == eiu_pkg::EIU_OFS_IDR) ? wr_data[N-1:0] : '0;
    assign wr_icr = (wr_stb && req.adr == eiu_pkg::EIU_OFS_ICR) ? wr_data[N-1:0] : '0;
    assign wr_en = (wr_stb && req.adr == eiu_pkg::EIU_OFS_EN) ? wr_data[N-1:0] : '0;
    assign wr_dis = (wr_stb && req.adr == eiu_pkg::EIU_OFS_DIS) ? wr_data[N-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////
    // config registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= '0;
            imr_ff <= '0;
            mode_ff <= '0;
            edge_ff <= '0;
            level_ff <= '0;
            filt_ff <= '0;
            asynchronous_select_ff <= '0;
        end else begin
            imr_ff <= (imr_ff | wr_ier) & ~wr_idr;
            ctrl_ff <= (ctrl_ff | wr_en) & ~wr_dis;
            // mode and polarity apply at once; an enabled lane may trigger
            // on the change itself, so software disables it first
            if (wr_stb && req.adr == eiu_pkg::EIU_OFS_MODE) begin
                mode_ff <= wr_data[N-1:0];
            end
            if (wr_stb && req.adr == eiu_pkg::EIU_OFS_EDGE) begin
                edge_ff <= wr_data[N-1:0];
            end
            if (wr_stb && req.adr == eiu_pkg::EIU_OFS_LEVEL) begin
                level_ff <= wr_data[N-1:0];
            end
            if (wr_stb && req.adr == eiu_pkg::EIU_OFS_FILTER) begin
                filt_ff <= wr_data[N-1:0];
            end
            if (wr_stb && req.adr == eiu_pkg::EIU_OFS_ASYNCHRONOUS_SELECT) begin
                asynchronous_select_ff <= wr_data[N-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-input detection, nmi is the top lane
    // nmi shares the same lane logic
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_lane
            logic vote, samp, pol, lvl_hit, edge_hit;
            // filtered lanes lag one cycle behind unfiltered ones
            // majority of latest three
            assign vote = (sync2_ff[g] & hist1_ff[g]) | (sync2_ff[g] & hist2_ff[g])
                        | (hist1_ff[g] & hist2_ff[g]);
            assign samp = filt_ff[g] ? vote : sync2_ff[g];
            assign pol = mode_ff[g] ? level_ff[g] : edge_ff[g];
            assign lvl_hit = pol ? samp : !samp;
            assign edge_hit = pol ? (samp && !prev_ff[g]) : (!samp && prev_ff[g]);
            assign trig[g] = mode_ff[g] ? lvl_hit : edge_hit;
            // raw pin on purpose: with the clock stopped no flop can sample it
            // raw pin as level, unfiltered, no clock needed
            assign asynchronous_select_hit[g] = ctrl_ff[g] && asynchronous_select_ff[g]
                                && (pin_all[g] == (mode_ff[g] ? level_ff[g] : edge_ff[g]));
        end
    endgenerate

    // two flop synchroniser
    // no reset: the chain follows the pins through reset, so the edge
    // detector sees no false edge when reset lets go
    always_ff @(posedge clk_i) begin
        sync1_ff <= pin_all;
        sync2_ff <= sync1_ff;
        hist1_ff <= sync2_ff;
        hist2_ff <= hist1_ff;
        prev_ff <= g_filtered_samples();
    end

    function automatic logic [N-1:0] g_filtered_samples();
        logic [N-1:0] s;
        for (int i = 0; i < N; i++) begin
            s[i] = filt_ff[i]
                 ? ((sync2_ff[i] & hist1_ff[i]) | (sync2_ff[i] & hist2_ff[i])
                    | (hist1_ff[i] & hist2_ff[i]))
                 : sync2_ff[i];
        end
        return s;
    endfunction

    // set wins over clear; disable clears; asynchronous_select path sets on the next edge
    // level lanes set again while the pin holds, so a clear only sticks
    // once the condition has gone away
    always_comb begin
        // asynchronous_select lanes bypass the synchronous detector entirely
        nxt_isr = ((isr_ff & ~wr_icr) | (trig & ~asynchronous_select_ff) | asynchronous_select_hit) & ctrl_ff & ~wr_dis;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            isr_ff <= '0;
            irq_ff <= '0;
            nmi_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            isr_ff <= nxt_isr;
            irq_ff <= nxt_isr[NUM_IRQ-1:0] & imr_ff[NUM_IRQ-1:0];
            nmi_ff <= nxt_isr[NMI_BIT] & imr_ff[NMI_BIT];
            wake_ff <= |nxt_isr;
        end
    end
    // the only output not from a flop: it must rise with no clock running
    // asynchronous_select wake seen without waiting for the status edge
    assign wake_request_o = wake_ff | (|asynchronous_select_hit);

    ////////////////////////////////////////////////////////////////////////
    // keypad scan
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_en_ff <= 1'b0;
            scan_presc_ff <= '0;
        end else if (wr_stb && req.adr == eiu_pkg::EIU_OFS_SCAN) begin
            scan_en_ff <= wr_data[eiu_pkg::EIU_SCAN_EN_BIT];
            scan_presc_ff <= wr_data[eiu_pkg::EIU_SCAN_PRESC_LSB +: eiu_pkg::EIU_SCAN_PRESC_W];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_state_ff <= eiu_pkg::EIU_SCAN_IDLE;
            scan_cnt_ff <= '0;
            scan_col_ff <= '0;
            scan_pin_ff <= '0;
        end else begin
            unique case (scan_state_ff)
                eiu_pkg::EIU_SCAN_IDLE: begin
                    scan_cnt_ff <= '0;
                    scan_col_ff <= '0;
                    if (scan_en_ff) begin
                        scan_state_ff <= eiu_pkg::EIU_SCAN_RUN;
                    end
                end
                eiu_pkg::EIU_SCAN_RUN: begin
                    if (!scan_en_ff) begin
                        scan_state_ff <= eiu_pkg::EIU_SCAN_IDLE;
                    end else if (scan_cnt_ff == (32'h1 << scan_presc_ff) - 32'h1) begin
                        // prescale p holds each column for 2^p cycles
                        // fixed rotation
                        scan_cnt_ff <= '0;
                        scan_col_ff <= (scan_col_ff == SW'(NUM_SCAN - 1)) ? '0
                                     : scan_col_ff + SW'(1);
                    end else begin
                        scan_cnt_ff <= scan_cnt_ff + 32'h1;
                    end
                    // oe lags scan_col_ff by an edge and the row passes two synchroniser flops,
                    // so the index matches only if that column is held for 4 cycles or more
                    // record the column of the key
                    if (|(nxt_isr[NUM_IRQ-1:0] & ~isr_ff[NUM_IRQ-1:0])) begin
                        scan_pin_ff <= scan_col_ff;
                    end
                end
            endcase
        end
    end

    // columns driven low one at a time, others released
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            col_ff <= '0;
            col_oe_n_ff <= '1;
        end else begin
            for (int c = 0; c < NUM_SCAN; c++) begin
                col_ff[c] <= 1'b0;
                col_oe_n_ff[c] <= !(scan_state_ff == eiu_pkg::EIU_SCAN_RUN
                                    && scan_col_ff == SW'(c));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone read mux and ack
    always_comb begin
        nxt_rdata = eiu_pkg::EIU_RST_UNMAPPED;
        unique case (req.adr)
            eiu_pkg::EIU_OFS_IMR: nxt_rdata[N-1:0] = imr_ff;
            eiu_pkg::EIU_OFS_ISR: nxt_rdata[N-1:0] = isr_ff;
            eiu_pkg::EIU_OFS_MODE: nxt_rdata[N-1:0] = mode_ff;
            eiu_pkg::EIU_OFS_EDGE: nxt_rdata[N-1:0] = edge_ff;
            eiu_pkg::EIU_OFS_LEVEL: nxt_rdata[N-1:0] = level_ff;
            eiu_pkg::EIU_OFS_FILTER: nxt_rdata[N-1:0] = filt_ff;
            eiu_pkg::EIU_OFS_ASYNCHRONOUS_SELECT: nxt_rdata[N-1:0] = asynchronous_select_ff;
            eiu_pkg::EIU_OFS_CTRL: nxt_rdata[N-1:0] = ctrl_ff;
            eiu_pkg::EIU_OFS_SCAN: begin
                nxt_rdata[eiu_pkg::EIU_SCAN_EN_BIT] = scan_en_ff;
                nxt_rdata[eiu_pkg::EIU_SCAN_PRESC_LSB +: eiu_pkg::EIU_SCAN_PRESC_W] =
                    scan_presc_ff;
                nxt_rdata[eiu_pkg::EIU_SCAN_PIN_LSB +: SW] = scan_pin_ff;
            end
            default: nxt_rdata = eiu_pkg::EIU_RST_UNMAPPED;
        endcase
    end

    // a write lands at the edge that raises ack; read data stands with ack
    // the ack blocks a second take, so the next access can follow the ack edge with cyc held high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= eiu_pkg::EIU_RST_ZERO;
        end else begin
            wb_ack_ff <= wr_stb || rd_stb;
            wb_dat_ff <= rd_stb ? nxt_rdata : eiu_pkg::EIU_RST_ZERO;
        end
    end

    assign wb_ack_o = wb_ack_ff;
    assign wb_dat_o = wb_dat_ff;
    assign irq_o = irq_ff;
    assign nmi_req_o = nmi_ff;
    assign keypad_column_out_o = col_ff;
    assign keypad_column_oe_n_o = col_oe_n_ff;
endmodule // eiu_external_irq_unit
`default_nettype wire

// ---- tb/eiu_irq_sink.sv ----
// far-side model: system interrupt controller and cpu nmi input
`timescale 1ns/1ps
`default_nettype none
module eiu_irq_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] irq_i,
    input wire logic nmi_i,
    output logic [7:0] seen_o,
    output logic nmi_seen_o
);
    always_ff @(posedge clk_i) begin
        seen_o <= rst_i ? 8'h00 : seen_o | irq_i;
        nmi_seen_o <= rst_i ? 1'b0 : nmi_seen_o | nmi_i;
    end
endmodule // eiu_irq_sink
`default_nettype wire

// ---- tb/eiu_irq_asserts.sv ----
// port checker for the external interrupt front end
`timescale 1ns/1ps
`default_nettype none
module eiu_irq_asserts #(parameter int NUM_IRQ = 8, parameter int NUM_SCAN = 8) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NUM_IRQ-1:0] ext_irq_pin_i,
    input wire logic nmi_pin_i,
    input wire logic [NUM_IRQ-1:0] irq_o,
    input wire logic nmi_req_o,
    input wire logic wake_request_o,
    input wire logic [NUM_SCAN-1:0] keypad_column_out_o,
    input wire logic [NUM_SCAN-1:0] keypad_column_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_idr_wr;
        s_req ##0 wb_we_i && wb_adr_i == eiu_pkg::EIU_OFS_IDR ##1 wb_ack_o;
    endsequence
    ////////////////////////////////////////////////////////////////
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_answer; s_req |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
    property p_rst_quiet; $fell(rst_i) |-> irq_o == '0 && !nmi_req_o && !wake_request_o; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("request after reset");
    property p_one_col; $countones(~keypad_column_oe_n_o) <= 1; endproperty
    a_one_col: assert property (p_one_col) else $error("two columns driven");
    property p_col_low; keypad_column_out_o == '0; endproperty
    a_col_low: assert property (p_col_low) else $error("column not low");
    property p_irq_wake; (|irq_o) || nmi_req_o |-> wake_request_o; endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("request without wake");
    property p_idr_clr; s_idr_wr |=> (irq_o & $past(wb_dat_i[NUM_IRQ-1:0], 2)) == '0; endproperty
    a_idr_clr: assert property (p_idr_clr) else $error("masked line still high");
endmodule // eiu_irq_asserts
`default_nettype wire

// ---- tb/tb_eiu_external_irq_unit.sv ----
// self-checking bench for the external interrupt front end
`timescale 1ns/1ps
`default_nettype none
module tb_eiu_external_irq_unit;
    logic clk_i;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic nmi = 1'b0;
    logic key = 1'b0;
    logic ack, nmi_req, wake, nseen;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [7:0] pins = 8'he5;
    logic [7:0] irq, oe_n, seen;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd, dato;
    logic [31:0] st = 32'd27;
    int n_fail = 0;
    int checks_done = 0;
    int m_imr = 0;
    int m_isr = 0;
    int t, prev, gap;
    // key shorts row 5 to column 3
    wire logic [7:0] pin_w = {pins[7:6], pins[5] & ~(key & ~oe_n[3]), pins[4:0]};
    eiu_external_irq_unit eiu_external_irq_unit_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dato), .wb_ack_o(ack),
        .ext_irq_pin_i(pin_w), .nmi_pin_i(nmi), .irq_o(irq), .nmi_req_o(nmi_req),
        .wake_request_o(wake), .keypad_column_out_o(), .keypad_column_oe_n_o(oe_n));
    eiu_irq_sink eiu_irq_sink_inst (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq),
        .nmi_i(nmi_req), .seen_o(seen), .nmi_seen_o(nseen));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        adr <= a;
        we <= w;
        wd <= d;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        // no answer in time counts against the run
        if (ack !== 1'b1) n_fail++;
        rd = dato;
        cyc <= 1'b0;
        if (w && a == 8'h00) m_imr |= d;
        if (w && a == 8'h04) m_imr &= ~d;
        if (w && (a == 8'h10 || a == 8'h34)) m_isr &= ~d;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // far beyond the few hundred cycles the run needs
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(8'h38, 0);
        rdchk(8'h24, 0);
        sel <= 4'h2;
        wb(8'h14, 1, 32'h1ff);
        sel <= 4'hf;
        rdchk(8'h14, 32'h100);
        wb(8'h14, 1, 32'h0c);
        wb(8'h18, 1, 32'h0a);
        wb(8'h1c, 1, 32'h0a);
        wb(8'h30, 1, 32'h0f);
        wb(8'h00, 1, 32'h05);
        rdchk(8'h0c, 0);
        @(posedge clk_i);
        pins <= 8'hea;
        repeat (2) @(posedge clk_i);
        #1 chk(irq, 0);
        @(posedge clk_i);
        m_isr = 'h0f;
        #1 chk(irq, m_isr & m_imr);
        rdchk(8'h0c, m_isr);
        wb(8'h04, 1, 32'h01);
        #1 chk(irq, m_isr & m_imr);
        wb(8'h10, 1, 32'h0f);
        m_isr |= 'h0c;
        rdchk(8'h0c, m_isr);
        chk(wake, 1);
        pins <= 8'he5;
        wb(8'h20, 1, 32'h02);
        @(posedge clk_i);
        pins <= 8'he6;
        @(posedge clk_i);
        pins <= 8'he5;
        repeat (6) @(posedge clk_i);
        m_isr |= 'h01;
        rdchk(8'h0c, m_isr);
        wb(8'h34, 1, 32'h1ff);
        wb(8'h18, 1, 32'h1a);
        wb(8'h28, 1, 32'h10);
        wb(8'h30, 1, 32'h10);
        #1 chk(wake, 0);
        @(posedge clk_i);
        pins <= 8'hf5;
        #1 chk(wake, 1);
        @(posedge clk_i);
        #1 chk(irq, 0);
        wb(8'h10, 1, 32'h10);
        rdchk(8'h0c, 'h10);
        wb(8'h34, 1, 32'h1ff);
        repeat (20) begin
            st = xs(st);
            @(posedge clk_i);
            pins <= st[7:0];
            nmi <= st[8];
            #1 chk({wake, nmi_req, irq}, 0);
        end
        pins <= 8'he5;
        nmi <= 1'b0;
        wb(8'h14, 1, 32'h120);
        wb(8'h1c, 1, 32'h100);
        wb(8'h28, 1, 32'h0);
        wb(8'h30, 1, 32'h100);
        wb(8'h00, 1, 32'h120);
        nmi <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk({nmi_req, irq}, 'h100);
        wb(8'h34, 1, 32'h100);
        nmi <= 1'b0;
        #1 chk({nseen, nmi_req}, 2'b10);
        wb(8'h30, 1, 32'h20);
        wb(8'h2c, 1, 32'h401);
        repeat (2) @(posedge clk_i);
        prev = $clog2(~oe_n);
        gap = -1000;
        // column rotation over a full turn, 2^4 cycles per column
        repeat (150) begin
            @(posedge clk_i);
            gap++;
            #1 if ($clog2(~oe_n) != prev) begin
                chk($clog2(~oe_n), (prev + 1) % 8);
                if (gap > 0) chk(gap, 16);
                gap = 0;
                prev = $clog2(~oe_n);
            end
        end
        // press only at a column start, so the latch sees column 3
        t = 0;
        while (oe_n[2] !== 1'b0 && t < 300) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 300) n_fail++;
        key <= 1'b1;
        t = 0;
        while (irq[5] !== 1'b1 && t < 300) begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 300) n_fail++;
        #1 chk(irq, 'h20);
        rdchk(8'h2c, 32'h0300_0401);
        chk(seen[5], 1);
        tally_and_finish();
    end
endmodule // tb_eiu_external_irq_unit
bind eiu_external_irq_unit eiu_irq_asserts #(.NUM_IRQ(NUM_IRQ), .NUM_SCAN(NUM_SCAN)) chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_pin_i(ext_irq_pin_i),
    .nmi_pin_i(nmi_pin_i), .irq_o(irq_o), .nmi_req_o(nmi_req_o),
    .wake_request_o(wake_request_o), .keypad_column_out_o(keypad_column_out_o),
    .keypad_column_oe_n_o(keypad_column_oe_n_o));
`default_nettype wire
